// ### src/nvot_seq.v
// program, erase and blank check duration sequencer
`timescale 1ns/1ps
`default_nettype none
`include "nvot_map.vh"
module nvot_seq (
   input  wire        core_clk,
   input  wire        reset_n,
   input  wire        osc_clk_in,
   input  wire [7:0]  flash_div,
   input  wire [7:0]  eeprom_div,
   input  wire        cmd_valid,
   input  wire [2:0]  cmd_op,
   input  wire        cmd_array,
   input  wire [15:0] bc_word_count,
   output reg         cmd_ready,
   output reg         busy,
   output reg         done,
   output reg         in_row,
   output reg  [5:0]  row_word_count,
   output reg         bc_addr_valid,
   output reg  [15:0] bc_addr,
   input  wire        bc_word_blank,
   output reg         bc_fail,
   output reg  [15:0] bc_fail_addr,
   output reg         op_timebase_tick
);
   // ***************************************************************
   // states
   // ***************************************************************
   localparam [4:0] ST_IDLE  = 5'b00001;
   localparam [4:0] ST_TB    = 5'b00010;
   localparam [4:0] ST_BUS   = 5'b00100;
   localparam [4:0] ST_SETUP = 5'b01000;
   localparam [4:0] ST_SCAN  = 5'b10000;

   reg [4:0]  state_q;
   reg [15:0] tb_left_q;
   reg [15:0] bus_left_q;
   reg        arr_q;
   reg [15:0] bc_last_q;
   reg [2:0]  osc_sync_q;
   reg [7:0]  div_cnt_q;

   // ***************************************************************
   // operation timebase
   // ***************************************************************
   // oscillator passes two flops before use; the third is edge history
   always @(posedge core_clk) begin
      if (!reset_n) begin
         osc_sync_q <= 3'h0;
      end else begin
         osc_sync_q <= {osc_sync_q[1:0], osc_clk_in};
      end
   end

   wire osc_rise = osc_sync_q[1] & ~osc_sync_q[2];
   // per-array divider; divider value n gives one tick per n+1 osc edges
   wire [7:0] div_sel = arr_q ? eeprom_div : flash_div;

   always @(posedge core_clk) begin
      if (!reset_n) begin
         div_cnt_q        <= 8'h00;
         op_timebase_tick <= 1'b0;
      end else begin
         op_timebase_tick <= 1'b0;
         if (state_q != ST_TB) begin
            // restart phase per word; no ticks may land in the bus part
            div_cnt_q <= 8'h00;
         end else if (osc_rise) begin
            if (div_cnt_q >= div_sel) begin
               div_cnt_q        <= 8'h00;
               op_timebase_tick <= 1'b1;
            end else begin
               div_cnt_q <= div_cnt_q + 8'h01;
            end
         end
      end
   end

   // ***************************************************************
   // sequencer
   // ***************************************************************
   always @(posedge core_clk) begin
      if (!reset_n) begin
         state_q        <= ST_IDLE;
         tb_left_q      <= 16'h0000;
         bus_left_q     <= 16'h0000;
         arr_q          <= 1'b0;
         bc_last_q      <= 16'h0000;
         cmd_ready      <= 1'b0;
         busy           <= 1'b0;
         done           <= 1'b0;
         in_row         <= 1'b0;
         row_word_count <= 6'h00;
         bc_addr_valid  <= 1'b0;
         bc_addr        <= 16'h0000;
         bc_fail        <= 1'b0;
         bc_fail_addr   <= 16'h0000;
      end else begin
         done      <= 1'b0;
         cmd_ready <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               busy      <= 1'b0;
               cmd_ready <= ~cmd_valid;
               if (cmd_valid) begin
                  busy   <= 1'b1;
                  arr_q  <= cmd_array;
                  in_row <= 1'b0;
                  case (cmd_op)
                     `NVOT_CMD_PROG: begin
                        tb_left_q      <= `NVOT_SW_TB;
                        bus_left_q     <= `NVOT_SW_BUS;
                        row_word_count <= 6'h01;
                        state_q        <= ST_TB;
                     end
                     `NVOT_CMD_SECTOR: begin
                        tb_left_q  <= `NVOT_SECTOR_TB;
                        bus_left_q <= 16'h0000;
                        state_q    <= ST_TB;
                     end
                     `NVOT_CMD_MASS: begin
                        tb_left_q  <= `NVOT_MASS_TB;
                        bus_left_q <= 16'h0000;
                        state_q    <= ST_TB;
                     end
                     `NVOT_CMD_BLANK: begin
                        bus_left_q <= `NVOT_BC_SETUP;
                        bc_last_q  <= bc_word_count - 16'h0001;
                        bc_fail    <= 1'b0;
                        state_q    <= ST_SETUP;
                     end
                     default: begin
                        busy    <= 1'b0;
                        done    <= 1'b1;                   // unknown op
                     end
                  endcase
               end
            end
            ST_TB: begin
               // timebase part of the duration
               if (op_timebase_tick) begin
                  if (tb_left_q == 16'h0001) begin
                     tb_left_q <= 16'h0000;
                     state_q   <= (bus_left_q == 16'h0000) ? ST_IDLE : ST_BUS;
                     if (bus_left_q == 16'h0000) begin
                        done <= 1'b1;
                        busy <= 1'b0;
                     end
                  end else begin
                     tb_left_q <= tb_left_q - 16'h0001;
                  end
               end
            end
            ST_BUS: begin
               // bus cycle part; row chaining decided at the last cycle
               if (bus_left_q == 16'h0001) begin
                  done      <= 1'b1;
                  cmd_ready <= 1'b1;
                  if (arr_q == `NVOT_ARR_FLASH &&
                      (row_word_count == 6'h01 || in_row) &&
                      row_word_count < `NVOT_ROW_WORDS &&
                      cmd_valid && cmd_op == `NVOT_CMD_PROG &&
                      cmd_array == `NVOT_ARR_FLASH) begin
                     in_row         <= 1'b1;
                     row_word_count <= row_word_count + 6'h01;
                     tb_left_q      <= `NVOT_CW_TB;
                     bus_left_q     <= `NVOT_CW_BUS;
                     state_q        <= ST_TB;
                  end else begin
                     in_row  <= 1'b0;
                     busy    <= 1'b0;
                     state_q <= ST_IDLE;
                  end
               end else begin
                  bus_left_q <= bus_left_q - 16'h0001;
               end
            end
            ST_SETUP: begin
               if (bus_left_q == 16'h0001) begin
                  bc_addr       <= 16'h0000;
                  bc_addr_valid <= 1'b1;
                  state_q       <= ST_SCAN;
               end else begin
                  bus_left_q <= bus_left_q - 16'h0001;
               end
            end
            ST_SCAN: begin
               // one bus cycle per word, stop at first non-blank
               if (!bc_word_blank) begin
                  bc_fail       <= 1'b1;
                  bc_fail_addr  <= bc_addr;
                  bc_addr_valid <= 1'b0;
                  done          <= 1'b1;
                  busy          <= 1'b0;
                  state_q       <= ST_IDLE;
               end else if (bc_addr == bc_last_q) begin
                  bc_addr_valid <= 1'b0;
                  done          <= 1'b1;
                  busy          <= 1'b0;
                  state_q       <= ST_IDLE;
               end else begin
                  bc_addr <= bc_addr + 16'h0001;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               busy    <= 1'b0;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ### src/nvot_map.vh
// constants for the nonvolatile array operation timing sequencer
`ifndef NVOT_MAP_VH
`define NVOT_MAP_VH
// row geometry
`define NVOT_ROW_WORDS        6'd32
`define NVOT_ROW_LAST         5'd31
// single word: timebase periods and bus cycles
`define NVOT_SW_TB            16'd9
`define NVOT_SW_BUS           16'd25
// consecutive word in a row
`define NVOT_CW_TB            16'd4
`define NVOT_CW_BUS           16'd9
// erase durations in timebase periods
`define NVOT_SECTOR_TB        16'd4000
`define NVOT_MASS_TB          16'd20000
// blank check setup in bus cycles
`define NVOT_BC_SETUP         16'd10
// commands
`define NVOT_CMD_PROG         3'd1
`define NVOT_CMD_SECTOR       3'd2
`define NVOT_CMD_MASS         3'd3
`define NVOT_CMD_BLANK        3'd4
// array select
`define NVOT_ARR_FLASH        1'b0
`define NVOT_ARR_EEPROM       1'b1
`endif

// ### tb/nvot_seq_chk.sv
// assertion checker bound to the operation timing sequencer
`timescale 1ns/1ps
`default_nettype none
module nvot_seq_chk (
   input wire logic        core_clk,
   input wire logic        reset_n,
   input wire logic [2:0]  cmd_op,
   input wire logic        cmd_array,
   input wire logic        busy,
   input wire logic        done,
   input wire logic        in_row,
   input wire logic [5:0]  row_word_count,
   input wire logic        bc_addr_valid,
   input wire logic [15:0] bc_addr,
   input wire logic        bc_word_blank,
   input wire logic        bc_fail,
   input wire logic        op_timebase_tick
);
   logic [15:0] tk_q;
   logic [7:0]  pc_q;
   logic [2:0]  op_q;
   logic        arr_q;
   // ticks in this word, bus cycles since last tick, command seen at accept
   always @(posedge core_clk) begin
      if (!reset_n || done || !busy) tk_q <= 16'h0000;
      else if (op_timebase_tick) tk_q <= tk_q + 16'h0001;
      if (!reset_n || op_timebase_tick) pc_q <= 8'h00;
      else if (pc_q != 8'hFF) pc_q <= pc_q + 8'h01; // saturates, no wrap
      if (!busy) op_q <= cmd_op;
      if (!busy) arr_q <= cmd_array;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // ****************************************
   // word and erase durations, row and scan shape
   // ****************************************
   property p_single; done && op_q == 3'h1 && !$past(in_row)
      |-> tk_q == 16'h0009 && pc_q == 8'h19; endproperty
   a_single: assert property (p_single) else $error("single word time");
   property p_chain; done && op_q == 3'h1 && $past(in_row)
      |-> tk_q == 16'h0004 && pc_q == 8'h09; endproperty
   a_chain: assert property (p_chain) else $error("row word time");
   property p_sector; done && op_q == 3'h2 |-> tk_q == 16'h0FA0; endproperty
   a_sector: assert property (p_sector) else $error("sector time");
   property p_mass; done && op_q == 3'h3 |-> tk_q == 16'h4E20; endproperty
   a_mass: assert property (p_mass) else $error("mass time");
   property p_eep; in_row |-> !arr_q; endproperty
   a_eep: assert property (p_eep) else $error("eeprom row");
   property p_rowmax; row_word_count <= 6'h20; endproperty
   a_rowmax: assert property (p_rowmax) else $error("row too long");
   property p_bcstep; bc_addr_valid && $past(bc_addr_valid)
      |-> bc_addr == $past(bc_addr) + 16'h0001; endproperty
   a_bcstep: assert property (p_bcstep) else $error("scan step");
   property p_bcfirst; $rose(bc_addr_valid) |-> bc_addr == 16'h0000; endproperty
   a_bcfirst: assert property (p_bcfirst) else $error("scan start");
   property p_bcstop; bc_addr_valid && !bc_word_blank |=> !bc_addr_valid;
   endproperty
   a_bcstop: assert property (p_bcstop) else $error("scan stop");
   c_row: cover property (done && $past(in_row));
   c_fail: cover property ($rose(bc_fail));
   c_mass: cover property (done && op_q == 3'h3);
endmodule
bind nvot_seq nvot_seq_chk nvot_seq_chk_i (.core_clk(core_clk),
   .reset_n(reset_n), .cmd_op(cmd_op), .cmd_array(cmd_array), .busy(busy),
   .done(done), .in_row(in_row), .row_word_count(row_word_count),
   .bc_addr_valid(bc_addr_valid), .bc_addr(bc_addr), .bc_fail(bc_fail),
   .bc_word_blank(bc_word_blank), .op_timebase_tick(op_timebase_tick));
`default_nettype wire

// ### tb/nvot_seq_tb.sv
// self-checking bench for the operation timing sequencer
`timescale 1ns/1ps
`default_nettype none
`include "nvot_map.vh"
`define CHK(a,b) begin total_checks++; if ((a) !== (b)) begin errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module nvot_seq_tb;
   logic        core_clk, reset_n, osc_clk_in, cmd_valid, cmd_array;
   logic [7:0]  flash_div, eeprom_div;
   logic [2:0]  cmd_op;
   logic [15:0] bc_word_count;
   wire         cmd_ready, busy, done, in_row, bc_addr_valid, bc_fail, tick;
   wire  [5:0]  row_word_count;
   wire  [15:0] bc_addr, bc_fail_addr;
   wire         bc_word_blank;
   int          errors, total_checks, cyc_n, bad_pos;
   logic [31:0] seed;
   nvot_seq nvot_seq_i (.core_clk(core_clk), .reset_n(reset_n),
      .osc_clk_in(osc_clk_in), .flash_div(flash_div), .eeprom_div(eeprom_div),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_array(cmd_array),
      .bc_word_count(bc_word_count), .cmd_ready(cmd_ready), .busy(busy),
      .done(done),
      .in_row(in_row), .row_word_count(row_word_count),
      .bc_addr_valid(bc_addr_valid), .bc_addr(bc_addr),
      .bc_word_blank(bc_word_blank), .bc_fail(bc_fail),
      .bc_fail_addr(bc_fail_addr), .op_timebase_tick(tick));
   // array answers blank except at one chosen word
   assign bc_word_blank = !(bc_addr_valid && bc_addr == 16'(bad_pos));
   // 100 MHz bus clock, far above the 1 MHz floor for operations
   initial begin core_clk = 0; forever #5 core_clk = ~core_clk; end
   // oscillator off the clock phase, one rise every two bus cycles
   initial begin osc_clk_in = 0; #3; forever #10 osc_clk_in = ~osc_clk_in; end
   // hang guard, about half again above the longest expected run
   always @(posedge core_clk) begin
      cyc_n++;
      if (cyc_n == 100000) begin errors++; print_verdict; end
   end
   function automatic logic [31:0] rnd(input logic [31:0] x);
      x ^= x << 13; x ^= x >> 17; x ^= x << 5; return x;
   endfunction
   function automatic int exp_ticks(input logic arr, input int i);
      return (!arr && i > 1 && (i - 1) % 32 != 0) ? 4 : 9;
   endfunction
   task automatic step; @(posedge core_clk); #1; endtask
   // raise the request, drop it once the operation has started
   task automatic start_op;
      cmd_valid = 1;
      for (int k = 0; k < 9 && !busy; k++) step;
      cmd_valid = 0;
   endtask
   task automatic wait_done(output int tk, output int post, output int len);
      tk = 0; post = 0; len = 0;
      do begin
         step; len++; post++;
         if (tick && busy && !done) begin tk++; post = 0; end
      end while (!done && len < 60000);
   endtask
   // n words with the request kept up so flash words chain
   task automatic prog(input logic arr, input int n);
      int tk, post, len, e, sum;
      cmd_op = `NVOT_CMD_PROG; cmd_array = arr; cmd_valid = 1; sum = 0;
      for (int i = 1; i <= n; i++) begin
         if (i == n) start_op;
         wait_done(tk, post, len);
         e = exp_ticks(arr, i); sum += tk;
         `CHK(tk, e)
         // one extra edge: the registered tick is consumed before bus part
         `CHK(post, ((e == 4) ? 9 : 25) + 1)
         `CHK(cmd_ready, 1'b1)
         `CHK(in_row & arr, 1'b0)
         if (e == 4) `CHK(row_word_count, 6'((i < n && i % 32 != 0) ?
            i % 32 + 1 : (i - 1) % 32 + 1))
         if (i == 32) `CHK(sum, 9 + 31 * 4)
      end
      step; step;
      `CHK(in_row, 1'b0)
   endtask
   task automatic erase(input logic [2:0] op, input logic arr, input int et);
      int tk, post, len;
      cmd_op = op; cmd_array = arr; start_op;
      wait_done(tk, post, len);
      `CHK(tk, et)
      `CHK((len + et / 2) / et, 2 * ((arr ? eeprom_div : flash_div) + 1))
   endtask
   task automatic blank(input int cnt, input int pos);
      int tk, post, len, s;
      bad_pos = pos; bc_word_count = 16'(cnt); cmd_op = `NVOT_CMD_BLANK;
      cmd_array = seed[3]; start_op;
      wait_done(tk, post, len);
      s = (pos < cnt) ? pos + 1 : cnt;
      `CHK(bc_fail, logic'(pos < cnt))
      if (pos < cnt) `CHK(bc_fail_addr, 16'(pos))
      `CHK(len, 10 + s)
   endtask
   task print_verdict;
      $display("checks=%0d errors=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      reset_n = 0; cmd_valid = 0; cmd_op = 3'h0; cmd_array = 0; bad_pos = 0;
      flash_div = 8'h00; eeprom_div = 8'h00; bc_word_count = 16'h0000;
      seed = 32'h05C0;
      repeat (6) @(posedge core_clk);
      #1 reset_n = 1;
      prog(0, 1); prog(1, 2); prog(0, 3);
      prog(0, 33);
      blank(8, 0); blank(5, 5);
      for (int k = 0; k < 6; k++) begin
         seed = rnd(seed); bad_pos = seed[7:0] + 1;
         seed = rnd(seed); blank(bad_pos, seed % (bad_pos + 2));
      end
      erase(`NVOT_CMD_SECTOR, 0, 4000);
      eeprom_div = 8'h01;
      erase(`NVOT_CMD_SECTOR, 1, 4000);
      erase(`NVOT_CMD_MASS, 0, 20000);
      print_verdict;
   end
endmodule
`default_nettype wire
